// ===== inc/arc_regs.svh
// Register offsets, field positions, reset values and frame counts for the result/channel/config bank
`ifndef ARC_REGS_SVH
`define ARC_REGS_SVH

`define ARC_ADDR_RESULT 5'h00
`define ARC_ADDR_CHANNEL 5'h01
`define ARC_ADDR_CONFIG 5'h02

`define ARC_FRAME_BITS 5'h10
`define ARC_ADDR_BITS 5
`define ARC_WR_FLAG_POS 10

`define ARC_RES_TAG_MSB 15
`define ARC_RES_TAG_LSB 13
`define ARC_RES_ALERT_POS 12
`define ARC_RES_SAMPLE_MSB 11

`define ARC_CFG_SOFT_RESET_REQUEST_POS 9
`define ARC_CFG_STICKY_POS 7
`define ARC_CFG_DRIVE_POS 6
`define ARC_CFG_BUSY_POS 5
`define ARC_CFG_PINFN_POS 4

`define ARC_CHAN_RST 8'h00
`define ARC_STICKY_RST 1'h1
`define ARC_DRIVE_RST 1'h1
`define ARC_BUSY_RST 1'h0
`define ARC_PINFN_RST 1'h0
`define ARC_RESULT_RST 16'h0000

`endif

// ===== inc/arc_pkg.sv
// Types shared by the result/channel/config register bank
package arc_pkg;

   typedef enum logic [1:0] {
      ARC_FR_IDLE = 2'b01,
      ARC_FR_SHIFT = 2'b10
   } arc_frame_t;

   typedef struct packed {
      logic [2:0] converted_input_tag;
      logic alert;
      logic [11:0] sample_value;
   } arc_result_t;

   typedef struct packed {
      logic sticky;
      logic drive_cmos;
      logic busy_sel;
      logic alarm_pin_function_select;
   } arc_cfg_t;

   typedef struct packed {
      logic [2:0] sclk_s;
      logic [2:0] csn_s;
      logic [1:0] sdi_s;
      arc_frame_t frame;
      logic [4:0] bit_cnt;
      logic [15:0] rx;
      logic [15:0] tx;
      logic rd_valid;
      logic [4:0] rd_addr;
      logic out_result;
      arc_result_t result;
      logic [7:0] chan_mask;
      logic [7:0] seq_mask;
      logic [7:0] new_mask;
      logic pend;
      logic [2:0] ptr;
      arc_cfg_t cfg;
      logic soft_reset_request;
      logic trim;
      logic alert_o;
      logic alert_oe;
      logic sdo_o;
      logic sdo_oe;
      logic [2:0] conv_ch;
   } arc_state_t;

endpackage : arc_pkg

// ===== hw/arc_regbank.sv
// Serial-accessed result, channel-enable and configuration registers with sequencer and alert pin
`timescale 1ns/1ps
`default_nettype none
`include "arc_regs.svh"

// Function
// RQ1: Read-only result word holds latest 12-bit sample
// RQ2: Top three bits carry converted input number
// RQ3: Bit 12 shows whether alert occurred
// RQ4: Smaller variants force unused tag bits zero
// RQ5: Eight enable bits choose sequenced inputs
// RQ6: Bit n enables input n; upper byte zero
// RQ7: Old sequence runs one more conversion
// RQ8: New write restarts at lowest enabled input
// RQ9: Config bit 9 resets control, result, alert
// RQ10: Soft-reset bit clears itself next cycle
// RQ11: Soft reset reloads trim from fuses
// RQ12: Sticky alert holds until read or reset
// RQ13: Non-sticky alert clears past hysteresis
// RQ14: Bit 6 picks open-drain or push-pull
// RQ15: Bit 5 with pin enable shows busy
// RQ16: Busy bit reads zero when pin disabled
// RQ17: Config bits 15-10 and 8 read zero
// RQ18: Sixteen-clock frame, address, write flag, commit
// RQ19: Read request answered in following frame
// RQ20: Bad-address writes ignored, reads return zero
// RQ21: Reserved bits ignore writes, read zero
module arc_regbank #(
   parameter int NUM_INPUTS = 8
) (
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic SCLK,
   input wire logic CS_N,
   input wire logic SDI,
   output logic SDO_O,
   output logic SDO_OE,
   input wire logic CONV_DONE,
   input wire logic [11:0] CONV_DATA,
   input wire logic CONV_BUSY,
   input wire logic ALERT_TRIP,
   input wire logic HYST_OK,
   output logic [2:0] CONV_CHANNEL,
   output logic ALERT_O,
   output logic ALERT_OE,
   output logic TRIM_RELOAD
);
   import arc_pkg::*;

   arc_state_t st_q;
   arc_state_t st_d;

   // Lowest enabled input; an empty mask parks on input 0
   function automatic logic [2:0] lowest_input(input logic [7:0] mask);
      logic [2:0] r;
      r = 3'h0;
      // Scan downward so the lowest set bit is the last one written
      for (int i = 7; i >= 0; i--) begin
         if (mask[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction : lowest_input

   // Next enabled input after cur, wrapping round to the lowest
   function automatic logic [2:0] next_input(input logic [7:0] mask, input logic [2:0] cur);
      logic [2:0] r;
      logic found;
      r = lowest_input(mask);
      found = 1'b0;
      // First enabled input above cur wins; none above wraps to the lowest
      for (int i = 0; i < 8; i++) begin
         if (!found && mask[i] && (3'(i) > cur)) begin
            r = 3'(i);
            found = 1'b1;
         end
      end
      return r;
   endfunction : next_input

   // Smaller variants have fewer inputs, so their upper tag bits are tied low
   function automatic logic [2:0] tag_of(input logic [2:0] ch);
      logic [2:0] r;
      r = ch;
      if (NUM_INPUTS <= 4) begin
         r[2] = 1'b0; // RQ4
      end
      if (NUM_INPUTS <= 2) begin
         r[1] = 1'b0; // RQ4
      end
      return r;
   endfunction : tag_of

   // Readback of the addressed register
   function automatic logic [15:0] read_word(input logic [4:0] addr, input arc_state_t s);
      logic [15:0] w;
      w = 16'h0000;
      case (addr)
         `ARC_ADDR_RESULT: begin
            w = s.result; // RQ1
         end
         `ARC_ADDR_CHANNEL: begin
            w[7:0] = s.chan_mask; // RQ6
         end
         `ARC_ADDR_CONFIG: begin
            w[`ARC_CFG_STICKY_POS] = s.cfg.sticky;
            w[`ARC_CFG_DRIVE_POS] = s.cfg.drive_cmos;
            // Busy select only reads back while the pin is in alert use
            w[`ARC_CFG_BUSY_POS] = s.cfg.busy_sel & s.cfg.alarm_pin_function_select; // RQ16
            w[`ARC_CFG_PINFN_POS] = s.cfg.alarm_pin_function_select;
            w[`ARC_CFG_SOFT_RESET_REQUEST_POS] = 1'b0; // RQ10
         end
         default: begin
            w = 16'h0000; // RQ20
         end
      endcase
      return w; // RQ17 RQ21
   endfunction : read_word

   // Combinational helpers, all given a value on every pass of the process
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;
   logic [4:0] f_addr;
   logic f_write;
   logic full_frame;
   logic pin_assert;
   logic pin_level;
   logic alert_set;
   logic alert_clr;
   logic chan_wr;

   always_comb begin
      st_d = st_q;

      // Only the second and third stages are looked at; stage one may be metastable
      st_d.sclk_s = {st_q.sclk_s[1:0], SCLK};
      st_d.csn_s = {st_q.csn_s[1:0], CS_N};
      st_d.sdi_s = {st_q.sdi_s[0], SDI};
      sclk_rise = st_q.sclk_s[1] & ~st_q.sclk_s[2];
      sclk_fall = ~st_q.sclk_s[1] & st_q.sclk_s[2];
      cs_fall = ~st_q.csn_s[1] & st_q.csn_s[2];
      cs_rise = st_q.csn_s[1] & ~st_q.csn_s[2];

      f_addr = st_q.rx[15:11];
      f_write = st_q.rx[`ARC_WR_FLAG_POS];
      full_frame = (st_q.bit_cnt == `ARC_FRAME_BITS);

      // One-cycle strobes default low
      st_d.trim = 1'b0;
      st_d.soft_reset_request = 1'b0; // RQ10

      alert_set = 1'b0;
      alert_clr = 1'b0;
      chan_wr = 1'b0;

      // Serial frame handling
      case (st_q.frame)
         ARC_FR_IDLE: begin
            st_d.sdo_oe = 1'b0;
            st_d.sdo_o = 1'b0;
            if (cs_fall) begin
               st_d.frame = ARC_FR_SHIFT;
               st_d.bit_cnt = 5'h00;
               st_d.rx = 16'h0000;
               // Whole word loaded at frame start so a later conversion cannot tear it
               if (st_q.rd_valid) begin
                  st_d.tx = read_word(st_q.rd_addr, st_q); // RQ19
                  st_d.out_result = (st_q.rd_addr == `ARC_ADDR_RESULT);
               end else begin
                  // No read pending: the result word goes out by default
                  st_d.tx = st_q.result;
                  st_d.out_result = 1'b1;
               end
               st_d.sdo_o = st_d.tx[15];
               st_d.sdo_oe = 1'b1;
            end
         end
         ARC_FR_SHIFT: begin
            if (cs_rise) begin
               st_d.frame = ARC_FR_IDLE;
               st_d.sdo_oe = 1'b0;
               st_d.sdo_o = 1'b0;
               st_d.rd_valid = 1'b0;
               // Short frames are dropped whole rather than half-applied
               if (full_frame) begin // RQ18
                  if (st_q.out_result) begin
                     alert_clr = 1'b1; // RQ12
                  end
                  if (f_write) begin // RQ18
                     case (f_addr)
                        `ARC_ADDR_CHANNEL: begin
                           st_d.chan_mask = st_q.rx[7:0]; // RQ5 RQ6 RQ21
                           st_d.new_mask = st_q.rx[7:0];
                           st_d.pend = 1'b1; // RQ7
                           chan_wr = 1'b1;
                        end
                        `ARC_ADDR_CONFIG: begin
                           st_d.cfg.sticky = st_q.rx[`ARC_CFG_STICKY_POS];
                           st_d.cfg.drive_cmos = st_q.rx[`ARC_CFG_DRIVE_POS]; // RQ14
                           st_d.cfg.busy_sel = st_q.rx[`ARC_CFG_BUSY_POS];
                           st_d.cfg.alarm_pin_function_select = st_q.rx[`ARC_CFG_PINFN_POS];
                           // Bit 9 is not stored; it only launches the one-cycle soft reset
                           st_d.soft_reset_request = st_q.rx[`ARC_CFG_SOFT_RESET_REQUEST_POS]; // RQ9
                        end
                        default: begin
                           // Read-only and unmapped addresses swallow the write
                           st_d.rd_valid = 1'b0; // RQ20
                        end
                     endcase
                  end else begin
                     st_d.rd_valid = 1'b1; // RQ19
                     st_d.rd_addr = f_addr;
                  end
               end
            end else begin
               // Bits past the sixteenth are dropped; the frame still commits
               if (sclk_rise && !full_frame) begin
                  st_d.rx = {st_q.rx[14:0], st_q.sdi_s[1]};
                  st_d.bit_cnt = st_q.bit_cnt + 5'h01;
               end
               if (sclk_fall && !full_frame) begin
                  st_d.tx = {st_q.tx[14:0], 1'b0};
                  st_d.sdo_o = st_q.tx[14];
               end
            end
         end
         default: begin
            // An illegal state code falls back to idle
            st_d.frame = ARC_FR_IDLE;
            st_d.sdo_oe = 1'b0;
         end
      endcase

      // Alert level: a new trip wins over a clear in the same cycle
      if (HYST_OK && !st_q.cfg.sticky) begin
         alert_clr = 1'b1; // RQ13
      end
      if (ALERT_TRIP) begin
         alert_set = 1'b1;
      end
      if (alert_set) begin
         st_d.result.alert = 1'b1; // RQ3
      end else if (alert_clr) begin
         st_d.result.alert = 1'b0; // RQ12 RQ13
      end

      // Sequencer and result capture
      if (CONV_DONE) begin
         // Sample and tag taken together so a read never mixes two conversions
         st_d.result.sample_value = CONV_DATA; // RQ1
         st_d.result.converted_input_tag = tag_of(st_q.ptr); // RQ2
         // The conversion in flight at the write still follows the old selection
         if (st_q.pend) begin
            st_d.seq_mask = st_q.new_mask;
            st_d.ptr = lowest_input(st_q.new_mask); // RQ8
            // A channel write landing in this same cycle stays pending
            st_d.pend = chan_wr; // RQ7
         end else begin
            st_d.ptr = next_input(st_q.seq_mask, st_q.ptr); // RQ5
         end
      end

      // Soft reset, one cycle after the commit
      if (st_q.soft_reset_request) begin
         st_d.result = `ARC_RESULT_RST; // RQ9
         // A trip in the reset cycle is kept, so no alert is lost
         if (alert_set) begin
            st_d.result.alert = 1'b1; // RQ3
         end
         st_d.seq_mask = st_q.chan_mask;
         st_d.ptr = lowest_input(st_q.chan_mask);
         st_d.pend = 1'b0;
         st_d.rd_valid = 1'b0;
         st_d.trim = 1'b1; // RQ11
      end

      // The converter learns its next input in the cycle the pointer moves
      st_d.conv_ch = st_d.ptr;

      // Alert pin: active low; open-drain only ever pulls down
      pin_assert = st_q.cfg.busy_sel ? CONV_BUSY : st_q.result.alert; // RQ15
      pin_level = ~pin_assert;
      // Pin function off: push-pull drives the idle level, open-drain lets go
      if (!st_q.cfg.alarm_pin_function_select) begin
         st_d.alert_o = st_q.cfg.drive_cmos;
         st_d.alert_oe = st_q.cfg.drive_cmos;
      end else if (st_q.cfg.drive_cmos) begin
         st_d.alert_o = pin_level; // RQ14
         st_d.alert_oe = 1'b1;
      end else begin
         st_d.alert_o = 1'b0; // RQ14
         st_d.alert_oe = ~pin_level;
      end
   end

   // Power-up reset only; the soft reset above leaves channel and config alone
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         st_q.sclk_s <= 3'h0;
         st_q.csn_s <= 3'h7;
         st_q.sdi_s <= 2'h0;
         st_q.frame <= ARC_FR_IDLE;
         st_q.bit_cnt <= 5'h00;
         st_q.rx <= 16'h0000;
         st_q.tx <= 16'h0000;
         st_q.rd_valid <= 1'b0;
         st_q.rd_addr <= 5'h00;
         st_q.out_result <= 1'b0;
         st_q.result <= `ARC_RESULT_RST;
         st_q.chan_mask <= `ARC_CHAN_RST;
         st_q.seq_mask <= `ARC_CHAN_RST;
         st_q.new_mask <= `ARC_CHAN_RST;
         st_q.pend <= 1'b0;
         st_q.ptr <= 3'h0;
         st_q.cfg.sticky <= `ARC_STICKY_RST;
         st_q.cfg.drive_cmos <= `ARC_DRIVE_RST;
         st_q.cfg.busy_sel <= `ARC_BUSY_RST;
         st_q.cfg.alarm_pin_function_select <= `ARC_PINFN_RST;
         st_q.soft_reset_request <= 1'b0;
         st_q.trim <= 1'b0;
         st_q.alert_o <= 1'b1;
         st_q.alert_oe <= 1'b1;
         st_q.sdo_o <= 1'b0;
         st_q.sdo_oe <= 1'b0;
         st_q.conv_ch <= 3'h0;
      end else begin
         st_q <= st_d;
      end
   end

   // Every port comes straight from a register
   assign SDO_O = st_q.sdo_o;
   assign SDO_OE = st_q.sdo_oe;
   assign CONV_CHANNEL = st_q.conv_ch;
   assign ALERT_O = st_q.alert_o;
   assign ALERT_OE = st_q.alert_oe;
   assign TRIM_RELOAD = st_q.trim;

endmodule : arc_regbank
`default_nettype wire

// ===== test/arc_regbank_monitor.sv
// Port-level checks on the register bank
`timescale 1ns/1ps
`default_nettype none
module arc_regbank_monitor #(
   parameter int NUM_INPUTS = 8
) (
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic SCLK,
   input wire logic CS_N,
   input wire logic SDI,
   input wire logic SDO_O,
   input wire logic SDO_OE,
   input wire logic CONV_DONE,
   input wire logic [11:0] CONV_DATA,
   input wire logic CONV_BUSY,
   input wire logic ALERT_TRIP,
   input wire logic HYST_OK,
   input wire logic [2:0] CONV_CHANNEL,
   input wire logic ALERT_O,
   input wire logic ALERT_OE,
   input wire logic TRIM_RELOAD
);
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RESET_N);
   sequence frame_open;
      $fell(CS_N);
   endsequence
   sequence frame_close;
      $rose(CS_N);
   endsequence
   oe_open_a: assert property (frame_open |-> ##[1:4] SDO_OE)
      else $error("output enable late");
   oe_close_a: assert property (frame_close |-> ##[1:4] !SDO_OE)
      else $error("output enable stuck");
   oe_hold_a: assert property (SDO_OE && !CS_N |=> SDO_OE)
      else $error("output enable dropped in frame");
   sdo_hold_a: assert property (SDO_OE && $rose(SCLK) |=> $stable(SDO_O) [*4])
      else $error("data out moved after sample edge");
   trim_pulse_a: assert property (TRIM_RELOAD |=> !TRIM_RELOAD)
      else $error("trim reload too long");
   trim_cause_a: assert property (TRIM_RELOAD |-> $past(CS_N, 3) && !$past(CS_N, 12))
      else $error("trim reload without frame end");
   chan_hold_a: assert property (!$stable(CONV_CHANNEL) |-> $past(CONV_DONE) || TRIM_RELOAD || $past(TRIM_RELOAD))
      else $error("channel moved without conversion");
   od_low_a: assert property (!ALERT_OE |-> !ALERT_O)
      else $error("alert driven high while released");
endmodule : arc_regbank_monitor
bind arc_regbank arc_regbank_monitor #(.NUM_INPUTS(NUM_INPUTS)) i_mon (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
   .SCLK(SCLK), .CS_N(CS_N), .SDI(SDI), .SDO_O(SDO_O), .SDO_OE(SDO_OE), .CONV_DONE(CONV_DONE),
   .CONV_DATA(CONV_DATA), .CONV_BUSY(CONV_BUSY), .ALERT_TRIP(ALERT_TRIP), .HYST_OK(HYST_OK),
   .CONV_CHANNEL(CONV_CHANNEL), .ALERT_O(ALERT_O), .ALERT_OE(ALERT_OE), .TRIM_RELOAD(TRIM_RELOAD));
`default_nettype wire

// ===== test/arc_host_model.sv
// Serial host model issuing sixteen-clock frames
`timescale 1ns/1ps
`default_nettype none
module arc_host_model (
   input wire logic CLK,
   output logic SCLK,
   output logic CS_N,
   output logic SDI,
   input wire logic SDO_O
);
   initial begin
      SCLK = 1'b0;
      CS_N = 1'b1;
      SDI = 1'b0;
   end
   // Clock stands low between frames; data sampled at the rising edge
   // Every change lands midway between system clock edges, so no pin races an edge
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      rx = 16'h0000;
      @(negedge CLK);
      #2.5;
      CS_N = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         SDI = tx[i];
         #60 SCLK = 1'b1;
         rx[i] = SDO_O;
         #65 SCLK = 1'b0;
      end
      #60 CS_N = 1'b1;
      SDI = ~SDI;
      #100;
   endtask : xfer
endmodule : arc_host_model
`default_nettype wire

// ===== test/arc_regbank_tb.sv
// Self-checking bench for the result, channel and configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "arc_regs.svh"
module arc_regbank_tb;
   import arc_pkg::*;
   logic clk, rst_n, sclk, cs_n, sdi, sdo, sdo_oe, done, busy, trip, hyst;
   logic [11:0] data;
   logic [2:0] chan;
   logic al_o, al_oe, trim;
   logic [15:0] rx;
   int num_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   int trims = 0;
   arc_regbank #(.NUM_INPUTS(8)) i_dut (.SYS_CLK(clk), .RESET_N(rst_n), .SCLK(sclk), .CS_N(cs_n), .SDI(sdi),
      .SDO_O(sdo), .SDO_OE(sdo_oe), .CONV_DONE(done), .CONV_DATA(data), .CONV_BUSY(busy), .ALERT_TRIP(trip),
      .HYST_OK(hyst), .CONV_CHANNEL(chan), .ALERT_O(al_o), .ALERT_OE(al_oe), .TRIM_RELOAD(trim));
   arc_host_model i_host (.CLK(clk), .SCLK(sclk), .CS_N(cs_n), .SDI(sdi), .SDO_O(sdo));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(negedge clk) begin
      cycles++;
      if (trim === 1'b1) trims++;
      if (cycles == 40000) begin
         num_errors++;
         end_sim();
      end
   end
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wr(input logic [4:0] a, input logic [9:0] d);
      i_host.xfer({a, 1'b1, d}, rx);
   endtask : wr
   // Frame that shifts out the pending read word, or the result word when no read is pending
   task automatic nop;
      i_host.xfer({5'h1F, 1'b1, 10'h000}, rx);
   endtask : nop
   task automatic rd(input logic [4:0] a);
      i_host.xfer({a, 1'b0, 10'h000}, rx);
      nop();
   endtask : rd
   task automatic pulse(input logic [11:0] d, input int k);
      @(negedge clk);
      done = (k == 0);
      trip = (k == 1);
      hyst = (k == 2);
      data = d;
      @(negedge clk);
      {done, trip, hyst} = 3'b000;
      @(negedge clk);
   endtask : pulse
   task automatic t_reset;
      rd(`ARC_ADDR_RESULT);
      check("result", 16'h0000, rx);
      rd(`ARC_ADDR_CHANNEL);
      check("channel", 16'h0000, rx);
      rd(`ARC_ADDR_CONFIG);
      check("config", 16'h00C0, rx);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_regs;
      wr(`ARC_ADDR_CHANNEL, 10'h3FF);
      rd(`ARC_ADDR_CHANNEL);
      check("channel", 16'h00FF, rx);
      wr(`ARC_ADDR_CONFIG, 10'h1FF);
      rd(`ARC_ADDR_CONFIG);
      check("config", 16'h00F0, rx);
      wr(`ARC_ADDR_CONFIG, 10'h0E0);
      rd(`ARC_ADDR_CONFIG);
      check("busy bit", 16'h00C0, rx);
      wr(5'h05, 10'h3FF);
      rd(5'h05);
      check("unmapped", 16'h0000, rx);
      wr(`ARC_ADDR_RESULT, 10'h3FF);
      nop();
      check("result", 16'h0000, rx);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_seq;
      logic [2:0] seq [4] = '{3'd2, 3'd3, 3'd5, 3'd2};
      logic [2:0] prev;
      prev = 3'd0;
      wr(`ARC_ADDR_CHANNEL, 10'h02C);
      check("chan", 16'h0000, {13'h0, chan});
      for (int i = 0; i < 4; i++) begin
         pulse({9'h1A5, i[2:0]}, 0);
         check("chan", {13'h0, seq[i]}, {13'h0, chan});
         nop();
         check("result", {prev, 1'b0, 9'h1A5, i[2:0]}, rx);
         prev = seq[i];
      end
      $display("t_seq done");
   endtask : t_seq
   task automatic t_alert;
      pulse(12'h000, 1);
      pulse(12'h000, 2);
      nop();
      check("alert", 16'h1000, rx & 16'h1000);
      nop();
      check("alert", 16'h0000, rx & 16'h1000);
      wr(`ARC_ADDR_CONFIG, 10'h040);
      pulse(12'h000, 1);
      pulse(12'h000, 2);
      nop();
      check("alert", 16'h0000, rx & 16'h1000);
      $display("t_alert done");
   endtask : t_alert
   task automatic t_pin;
      wr(`ARC_ADDR_CONFIG, 10'h070);
      @(negedge clk);
      busy = 1'b1;
      repeat (3) @(negedge clk);
      check("pin", 16'h0002, {14'h0, al_oe, al_o});
      busy = 1'b0;
      wr(`ARC_ADDR_CONFIG, 10'h010);
      pulse(12'h000, 1);
      check("pin", 16'h0002, {14'h0, al_oe, al_o});
      nop();
      check("pin", 16'h0000, {14'h0, al_oe, al_o});
      $display("t_pin done");
   endtask : t_pin
   task automatic t_soft_reset_request;
      int base;
      pulse(12'h777, 0);
      base = trims;
      wr(`ARC_ADDR_CONFIG, 10'h2C0);
      check("trim", 16'h0001, 16'(trims - base));
      check("chan", 16'h0002, {13'h0, chan});
      nop();
      check("result", 16'h0000, rx);
      rd(`ARC_ADDR_CONFIG);
      check("config", 16'h00C0, rx);
      rd(`ARC_ADDR_CHANNEL);
      check("channel", 16'h002C, rx);
      $display("t_soft_reset_request done");
   endtask : t_soft_reset_request
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      rst_n = 1'b0;
      {done, busy, trip, hyst} = 4'h0;
      data = 12'h000;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_reset();
      t_regs();
      t_seq();
      t_alert();
      t_pin();
      t_soft_reset_request();
      end_sim();
   end
endmodule : arc_regbank_tb
`default_nettype wire
